/* common/lfp_pkg.sv */
// lfp_pkg: register map, field layout, reset values and timing constants
package lfp_pkg;

    // =========================================================
    // register bus
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;

    localparam logic [2:0] ADDR_MODE_CTRL = 3'h0;
    localparam logic [2:0] ADDR_INDICATOR = 3'h1;
    localparam logic [2:0] ADDR_VOLTAGE = 3'h2;
    localparam logic [2:0] ADDR_CURRENT_A = 3'h3;
    localparam logic [2:0] ADDR_CURRENT_B = 3'h4;
    localparam logic [2:0] ADDR_STATUS = 3'h5;
    localparam logic [2:0] ADDR_RAMP = 3'h6;

    // =========================================================
    // field positions
    localparam int MODE_LSB = 0;
    localparam int FVM_BIT = 2;
    localparam int LEDSEL_LSB = 3;
    localparam int TSEN_BIT = 6;
    localparam int BATMON_BIT = 7;
    localparam int IND_LSB = 0;
    localparam int IND_ON_BIT = 4;
    localparam int REV_SEL_BIT = 5;
    localparam int PWM_EN_BIT = 6;
    localparam int OV_LSB = 0;
    localparam int DROOP_LSB = 4;

    // =========================================================
    // operating modes and codes
    typedef enum logic [1:0] {
        LFP_MODE_OFF = 2'b00,
        LFP_MODE_VIDEO = 2'b01,
        LFP_MODE_FLASH = 2'b10,
        LFP_MODE_VOLT = 2'b11
    } lfp_mode_t;

    localparam logic [3:0] OV_HIGH_MIN = 4'h5;
    localparam logic [2:0] IND_MAX_STEP = 3'h7;
    localparam logic [1:0] DIE_COOL = 2'h0;
    localparam logic [1:0] DIE_WARM = 2'h1;
    localparam logic [1:0] DIE_HOT = 2'h2;
    localparam logic [1:0] DIE_TRIP = 2'h3;

    // =========================================================
    // reset values
    localparam logic [7:0] RST_MODE_CTRL = 8'h00;
    localparam logic [7:0] RST_INDICATOR = 8'h00;
    localparam logic [7:0] RST_VOLTAGE = 8'h00;
    localparam logic [4:0] RST_CURRENT_A = 5'h00;
    localparam logic [5:0] RST_CURRENT_B = 6'h00;

    // =========================================================
    // timing
    localparam longint CLK_HZ = 50_000_000;
    localparam longint PWM_HZ = 30_000;
    localparam longint T_RISE_NS = 12_000;
    localparam longint T_FALL_NS = 500;
    localparam longint CLK_NS = 1_000_000_000 / CLK_HZ;
    localparam logic [10:0] PWM_PERIOD_CYC = 11'(CLK_HZ / PWM_HZ);
    localparam logic [9:0] RISE_CYC = 10'((T_RISE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [9:0] FALL_CYC = 10'(T_FALL_NS / CLK_NS);

endpackage

/* logic/lfp_sync.sv */
// lfp_sync: two-stage synchroniser for a vector of asynchronous levels
`timescale 1ns/1ns
`default_nettype none

module lfp_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync_out;

    // first stage feeds only the second stage
    always_comb begin
        next_meta = rst_n ? async_in : '0;
        next_sync_out = rst_n ? meta : '0;
    end

    always_ff @(posedge core_clk) begin
        meta <= next_meta;
        sync_out <= next_sync_out;
    end

endmodule // lfp_sync

`default_nettype wire

/* logic/lfp_ctrl.sv */
// lfp_ctrl: flash LED driver control, protection flags and status
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module lfp_ctrl
    import lfp_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // analog comparators and pins (asynchronous)
    input wire logic ts_below_warn,
    input wire logic ts_below_hot,
    input wire logic ovp_trip,
    input wire logic led_short,
    input wire logic uvlo_low,
    input wire logic die_over_55,
    input wire logic die_over_70,
    input wire logic die_over_160,
    input wire logic die_below_140,
    input wire logic droop_trip,
    input wire logic tx_mask,
    // power stage and LED controls
    output logic power_switch_en,
    output logic rectifier_en,
    output logic overvoltage_clamp,
    output logic ovp_high_sel,
    output logic shutdown,
    output logic [2:0] led_gate,
    output logic [5:0] led_current_steps,
    output logic safety_timeout_en,
    // indicator
    output logic indicator_en,
    output logic [2:0] indicator_level,
    output logic converter_output_pulldown,
    // droop, temperature and die monitors
    output logic droop_sample,
    output logic [2:0] droop_limit,
    output logic ts_monitor_active,
    output logic die_monitor_active
);

    // =========================================================
    // synchronisers
    localparam int NSYNC = 11;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] syn;
    logic ts_warn_s, ts_hot_s, ovp_s, short_s, uvlo_s;
    logic d55_s, d70_s, d160_s, d140_s, droop_s, txm_s;

    assign raw_in = {tx_mask, droop_trip, die_below_140, die_over_160,
                     die_over_70, die_over_55, uvlo_low, led_short,
                     ovp_trip, ts_below_hot, ts_below_warn};

    lfp_sync #(.WIDTH(NSYNC)) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in(raw_in),
        .sync_out(syn)
    );

    assign {txm_s, droop_s, d140_s, d160_s, d70_s, d55_s, uvlo_s, short_s,
            ovp_s, ts_hot_s, ts_warn_s} = syn;

    // =========================================================
    // software registers
    logic [7:0] mode_ctrl, next_mode_ctrl;
    logic [7:0] ind_cfg, next_ind_cfg;
    logic [7:0] volt_cfg, next_volt_cfg;
    logic [4:0] flash_current_a, next_flash_current_a;
    logic [5:0] flash_current_b, next_flash_current_b;

    lfp_mode_t mode;
    logic forced_voltage_mode_bit, temp_sense_enable, battery_monitor_enable;
    logic [2:0] led_select_bits, droop_setting;
    logic [3:0] indicator_setting, output_voltage_code;

    assign mode = lfp_mode_t'(mode_ctrl[MODE_LSB +: 2]);
    assign forced_voltage_mode_bit = mode_ctrl[FVM_BIT];
    assign led_select_bits = mode_ctrl[LEDSEL_LSB +: 3];
    assign temp_sense_enable = mode_ctrl[TSEN_BIT];
    assign battery_monitor_enable = mode_ctrl[BATMON_BIT];
    assign indicator_setting = ind_cfg[IND_LSB +: 4];
    assign output_voltage_code = volt_cfg[OV_LSB +: 4];
    assign droop_setting = volt_cfg[DROOP_LSB +: 3];

    // =========================================================
    // mode decode
    logic led_mode, voltage_mode, pwm_mode, flash_mode;
    logic tsd_active, led_hot_flag;
    logic regulating, hot_event, tsd_event, wr_hit_mode;

    assign led_mode = (mode == LFP_MODE_VIDEO) || (mode == LFP_MODE_FLASH);
    assign voltage_mode = (mode == LFP_MODE_VOLT) || forced_voltage_mode_bit;
    assign flash_mode = (mode == LFP_MODE_FLASH) && !tsd_active;
    assign shutdown = (mode == LFP_MODE_OFF) && !forced_voltage_mode_bit;
    assign regulating = led_mode && !tsd_active;
    assign pwm_mode = ind_cfg[PWM_EN_BIT] && (mode == LFP_MODE_VIDEO)
                      && forced_voltage_mode_bit;
    assign ts_monitor_active = led_mode
        || ((mode == LFP_MODE_VOLT) && temp_sense_enable);
    assign hot_event = regulating && ts_monitor_active && ts_hot_s;
    assign tsd_event = d160_s && !shutdown;
    assign wr_hit_mode = reg_wr && (reg_addr == ADDR_MODE_CTRL);

    // hardware suspension overrides a concurrent software write
    always_comb begin
        next_mode_ctrl = mode_ctrl;
        next_ind_cfg = ind_cfg;
        next_volt_cfg = volt_cfg;
        next_flash_current_a = flash_current_a;
        next_flash_current_b = flash_current_b;
        if (wr_hit_mode) begin
            next_mode_ctrl = reg_wdata;
        end
        if (reg_wr && (reg_addr == ADDR_INDICATOR)) begin
            next_ind_cfg = reg_wdata;
        end
        if (reg_wr && (reg_addr == ADDR_VOLTAGE)) begin
            next_volt_cfg = reg_wdata;
        end
        if (reg_wr && (reg_addr == ADDR_CURRENT_A)) begin
            next_flash_current_a = reg_wdata[4:0];
        end
        if (reg_wr && (reg_addr == ADDR_CURRENT_B)) begin
            next_flash_current_b = reg_wdata[5:0];
        end
        if (hot_event) begin
            next_mode_ctrl[MODE_LSB +: 2] = LFP_MODE_OFF;
        end
        if (tsd_event && led_mode && !voltage_mode) begin
            next_mode_ctrl[MODE_LSB +: 2] = LFP_MODE_OFF;
        end
        if (!rst_n) begin
            next_mode_ctrl = RST_MODE_CTRL;
            next_ind_cfg = RST_INDICATOR;
            next_volt_cfg = RST_VOLTAGE;
            next_flash_current_a = RST_CURRENT_A;
            next_flash_current_b = RST_CURRENT_B;
        end
    end

    always_ff @(posedge core_clk) begin
        mode_ctrl <= next_mode_ctrl;
        ind_cfg <= next_ind_cfg;
        volt_cfg <= next_volt_cfg;
        flash_current_a <= next_flash_current_a;
        flash_current_b <= next_flash_current_b;
    end

    // =========================================================
    // flags and die temperature
    logic led_failure_flag, next_led_failure_flag;
    logic next_led_hot_flag, next_tsd_active;
    logic [1:0] die_temperature_field, next_die_temperature_field;
    logic [1:0] die_band;
    logic led_warning_flag, status_rd;

    assign status_rd = reg_rd && (reg_addr == ADDR_STATUS);
    assign led_warning_flag = ts_monitor_active && ts_warn_s;
    assign die_monitor_active = !shutdown;
    assign die_band = d70_s ? DIE_HOT : (d55_s ? DIE_WARM : DIE_COOL);

    // sticky flags: a set in the read cycle wins over the clear
    always_comb begin
        next_led_hot_flag = led_hot_flag;
        next_led_failure_flag = led_failure_flag;
        next_tsd_active = tsd_active;
        next_die_temperature_field = die_temperature_field;
        if (status_rd) begin
            next_led_hot_flag = 1'b0;
            next_led_failure_flag = 1'b0;
        end
        if (hot_event) begin
            next_led_hot_flag = 1'b1;
        end
        if (regulating && (ovp_s || short_s)) begin
            next_led_failure_flag = 1'b1;
        end
        if (tsd_event) begin
            next_tsd_active = 1'b1;
        end else if (d140_s) begin
            next_tsd_active = 1'b0;
        end
        if (die_temperature_field != DIE_TRIP || status_rd) begin
            next_die_temperature_field = shutdown ? DIE_COOL : die_band;
        end
        if (tsd_event || hot_event) begin
            next_die_temperature_field = DIE_TRIP;
        end
        if (!rst_n) begin
            next_led_hot_flag = 1'b0;
            next_led_failure_flag = 1'b0;
            next_tsd_active = 1'b0;
            next_die_temperature_field = DIE_COOL;
        end
    end

    always_ff @(posedge core_clk) begin
        led_hot_flag <= next_led_hot_flag;
        led_failure_flag <= next_led_failure_flag;
        tsd_active <= next_tsd_active;
        die_temperature_field <= next_die_temperature_field;
    end

    // =========================================================
    // dimming PWM
    logic [10:0] pwm_cnt, next_pwm_cnt;
    logic [14:0] duty_thr;
    logic pwm_on;

    // setting/16 of the period; a setting of 0 keeps LEDs dark
    assign duty_thr = 15'((15'(PWM_PERIOD_CYC) * 15'(indicator_setting)) >> 4);
    assign pwm_on = 15'(pwm_cnt) < duty_thr;

    always_comb begin
        next_pwm_cnt = pwm_cnt + 11'h001;
        if (pwm_cnt == PWM_PERIOD_CYC - 11'h001 || !rst_n) begin
            next_pwm_cnt = 11'h000;
        end
    end

    always_ff @(posedge core_clk) begin
        pwm_cnt <= next_pwm_cnt;
    end

    // =========================================================
    // current ramp and droop monitor
    logic [5:0] target_steps, next_steps;
    logic [9:0] ramp_tmr, next_ramp_tmr;
    logic flash_q, next_flash_q;
    logic droop_halt, next_droop_halt;
    logic [2:0] next_droop_limit;
    logic next_droop_sample, flash_start, droop_watch;

    assign flash_start = flash_mode && !flash_q;
    assign droop_watch = battery_monitor_enable && !txm_s;
    assign target_steps = !regulating ? 6'h00
        : (flash_mode ? flash_current_b : {1'b0, flash_current_a});

    always_comb begin
        next_steps = led_current_steps;
        next_ramp_tmr = ramp_tmr + 10'h001;
        next_flash_q = flash_mode;
        next_droop_halt = droop_halt;
        next_droop_limit = droop_limit;
        next_droop_sample = 1'b0;
        if (flash_start) begin
            next_droop_sample = battery_monitor_enable;
            next_droop_limit = droop_setting;
            next_droop_halt = 1'b0;
        end else if (!flash_mode) begin
            next_droop_halt = 1'b0;
        end else if (droop_watch && droop_s
                     && led_current_steps < target_steps) begin
            next_droop_halt = 1'b1;
        end
        if (led_current_steps < target_steps && !next_droop_halt) begin
            if (ramp_tmr >= RISE_CYC - 10'h001) begin
                next_steps = led_current_steps + 6'h01;
                next_ramp_tmr = 10'h000;
            end
        end else if (led_current_steps > target_steps) begin
            if (ramp_tmr >= FALL_CYC - 10'h001) begin
                next_steps = led_current_steps - 6'h01;
                next_ramp_tmr = 10'h000;
            end
        end else begin
            next_ramp_tmr = 10'h000;
        end
        if (!rst_n) begin
            next_steps = 6'h00;
            next_ramp_tmr = 10'h000;
            next_flash_q = 1'b0;
            next_droop_halt = 1'b0;
            next_droop_limit = 3'h0;
            next_droop_sample = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        led_current_steps <= next_steps;
        ramp_tmr <= next_ramp_tmr;
        flash_q <= next_flash_q;
        droop_halt <= next_droop_halt;
        droop_limit <= next_droop_limit;
        droop_sample <= next_droop_sample;
    end

    // =========================================================
    // power stage and LED outputs
    always_comb begin
        power_switch_en = !shutdown && !tsd_active && !uvlo_s;
        rectifier_en = !shutdown && !tsd_active && !uvlo_s;
        ovp_high_sel = output_voltage_code >= OV_HIGH_MIN;
        overvoltage_clamp = regulating && ovp_s;
        safety_timeout_en = !pwm_mode;
        indicator_en = ind_cfg[IND_ON_BIT];
        indicator_level = (indicator_setting > 4'(IND_MAX_STEP))
            ? IND_MAX_STEP : indicator_setting[2:0];
        converter_output_pulldown = ind_cfg[REV_SEL_BIT]
            && ind_cfg[IND_ON_BIT] && shutdown;
        // gates on only while regulating; dimming chops selected LEDs
        led_gate = (regulating && (!pwm_mode || pwm_on))
            ? led_select_bits : 3'h0;
    end

    // =========================================================
    // read data, one cycle after the strobe
    logic [DATA_W-1:0] next_rdata;

    always_comb begin
        next_rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                ADDR_MODE_CTRL: next_rdata = mode_ctrl;
                ADDR_INDICATOR: next_rdata = ind_cfg;
                ADDR_VOLTAGE: next_rdata = volt_cfg;
                ADDR_CURRENT_A: next_rdata = {3'h0, flash_current_a};
                ADDR_CURRENT_B: next_rdata = {2'h0, flash_current_b};
                ADDR_STATUS: next_rdata = {1'b0, droop_halt, tsd_active,
                                           die_temperature_field,
                                           led_failure_flag, led_hot_flag,
                                           led_warning_flag};
                ADDR_RAMP: next_rdata = {2'h0, led_current_steps};
                default: next_rdata = 8'h00;
            endcase
        end
        if (!rst_n) begin
            next_rdata = 8'h00;
        end
    end

    always_ff @(posedge core_clk) begin
        reg_rdata <= next_rdata;
    end

endmodule // lfp_ctrl

`default_nettype wire

/* bench/lfp_ctrl_props.sv */
// lfp_ctrl_props: port-level assertions for the flash LED control block
`timescale 1ns/1ns
`default_nettype none

module lfp_ctrl_props
    import lfp_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    // watched levels
    input wire logic uvlo_low,
    input wire logic power_switch_en,
    input wire logic rectifier_en,
    input wire logic ovp_high_sel,
    input wire logic shutdown,
    input wire logic [2:0] led_gate,
    input wire logic [5:0] led_current_steps,
    input wire logic indicator_en,
    input wire logic [2:0] indicator_level,
    input wire logic converter_output_pulldown,
    input wire logic droop_sample,
    input wire logic die_monitor_active
);
    // =========================================================
    // helpers
    logic [DATA_W-1:0] wdata_q;
    always_ff @(posedge core_clk) begin
        wdata_q <= reg_wdata;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // =========================================================
    // properties
    // sync chain delay: a level seen two edges ago must be acted on now
    property p_uvlo;
        $past(rst_n) && $past(rst_n, 2) && $past(uvlo_low, 2)
            |-> !power_switch_en && !rectifier_en;
    endproperty
    a_uvlo: assert property (p_uvlo) else $error("switch on in lockout");

    property p_ovsel;
        reg_wr && reg_addr == ADDR_VOLTAGE
            |=> ovp_high_sel == (wdata_q[3:0] >= OV_HIGH_MIN);
    endproperty
    a_ovsel: assert property (p_ovsel) else $error("bad ovp select");

    property p_indlvl;
        reg_wr && reg_addr == ADDR_INDICATOR
            |=> indicator_level == (wdata_q[3] ? 3'h7 : wdata_q[2:0]);
    endproperty
    a_indlvl: assert property (p_indlvl) else $error("bad indicator level");

    property p_revpath;
        converter_output_pulldown |-> shutdown && indicator_en;
    endproperty
    a_revpath: assert property (p_revpath) else $error("pulldown not off");

    property p_diemon;
        shutdown |-> !die_monitor_active ##1 shutdown || die_monitor_active;
    endproperty
    a_diemon: assert property (p_diemon) else $error("die monitor state");

    property p_step;
        $past(rst_n) |-> 6'(led_current_steps - $past(led_current_steps))
            inside {6'h00, 6'h01, 6'h3f};
    endproperty
    a_step: assert property (p_step) else $error("ramp jumped");

    property p_rise_gap;
        $past(rst_n) && led_current_steps > $past(led_current_steps)
            |=> (led_current_steps <= $past(led_current_steps)) [*8];
    endproperty
    a_rise_gap: assert property (p_rise_gap) else $error("ramp too fast");

    property p_gate;
        led_gate != 3'h0 |-> !shutdown;
    endproperty
    a_gate: assert property (p_gate) else $error("gate in shutdown");

    property p_sample;
        droop_sample |-> !shutdown ##1 !droop_sample;
    endproperty
    a_sample: assert property (p_sample) else $error("bad droop sample");

endmodule // lfp_ctrl_props

bind lfp_ctrl lfp_ctrl_props u_props (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .uvlo_low(uvlo_low),
    .power_switch_en(power_switch_en),
    .rectifier_en(rectifier_en),
    .ovp_high_sel(ovp_high_sel),
    .shutdown(shutdown),
    .led_gate(led_gate),
    .led_current_steps(led_current_steps),
    .indicator_en(indicator_en),
    .indicator_level(indicator_level),
    .converter_output_pulldown(converter_output_pulldown),
    .droop_sample(droop_sample),
    .die_monitor_active(die_monitor_active)
);

`default_nettype wire

/* bench/lfp_host.sv */
// lfp_host: register-bus master standing in for the camera host
`timescale 1ns/1ns
`default_nettype none

module lfp_host
    import lfp_pkg::*;
(
    // clock
    input wire logic core_clk,
    // register port
    output logic [ADDR_W-1:0] reg_addr,
    output logic [DATA_W-1:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata
);
    initial begin
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // write returns one edge late so its effect is settled for checks
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
        d = reg_rdata;
    endtask

endmodule // lfp_host

`default_nettype wire

/* bench/lfp_ctrl_test.sv */
// lfp_ctrl_test: self-checking bench for the flash LED control block
`timescale 1ns/1ns
`default_nettype none

module lfp_ctrl_test;
    import lfp_pkg::*;
    logic core_clk, rst_n, reg_wr, reg_rd;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    logic ts_below_warn, ts_below_hot, ovp_trip, led_short, uvlo_low;
    logic die_over_55, die_over_70, die_over_160, die_below_140;
    logic droop_trip, tx_mask, power_switch_en, rectifier_en;
    logic overvoltage_clamp, ovp_high_sel, shutdown, safety_timeout_en;
    logic indicator_en, converter_output_pulldown, droop_sample;
    logic ts_monitor_active, die_monitor_active;
    logic [2:0] led_gate, indicator_level, droop_limit;
    logic [5:0] led_current_steps;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc_count = 0;

    lfp_ctrl DUT (.*);
    lfp_host HOST (.*);

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // =========================================================
    // helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] d;
        HOST.rd(a, d);
        chk(d, exp);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // four ramp runs and one dimming period need under 8000 cycles
    always @(posedge core_clk) begin
        cyc_count <= cyc_count + 1;
        if (cyc_count == 20000) begin
            bad_count++;
            end_of_test();
        end
    end

    // =========================================================
    // scenarios
    task automatic t_regs();
        rdchk(ADDR_MODE_CTRL, RST_MODE_CTRL);
        rdchk(ADDR_INDICATOR, RST_INDICATOR);
        rdchk(ADDR_VOLTAGE, RST_VOLTAGE);
        rdchk(ADDR_CURRENT_B, 8'(RST_CURRENT_B));
        HOST.wr(ADDR_CURRENT_A, 8'hff);
        rdchk(ADDR_CURRENT_A, 8'h1f);
        HOST.wr(ADDR_CURRENT_A, 8'h00);
        HOST.wr(ADDR_STATUS, 8'hff);
        rdchk(ADDR_STATUS, 8'h00);
        rdchk(3'h7, 8'h00);
        chk(8'(shutdown), 8'h01);
        chk(8'(die_monitor_active), 8'h00);
        $display("test regs done");
    endtask

    task automatic t_ind_ov();
        for (int i = 0; i < 16; i++) begin
            HOST.wr(ADDR_INDICATOR, 8'h30 | 8'(i));
            HOST.wr(ADDR_VOLTAGE, 8'(i));
            chk(8'(indicator_level), 8'(i > 7 ? 7 : i));
            chk(8'(indicator_en), 8'h01);
            chk(8'(converter_output_pulldown), 8'h01);
            chk(8'(ovp_high_sel), 8'(i >= 5));
        end
        HOST.wr(ADDR_MODE_CTRL, 8'h04);
        chk(8'(converter_output_pulldown), 8'h00);
        $display("test indicator done");
    endtask

    task automatic t_pwm();
        int hi;
        hi = 0;
        HOST.wr(ADDR_INDICATOR, 8'h48);
        HOST.wr(ADDR_MODE_CTRL, 8'h2d);
        chk(8'(safety_timeout_en), 8'h00);
        repeat (1666) begin
            @(posedge core_clk);
            if (led_gate === 3'h5)
                hi++;
        end
        chk(8'(hi == 833), 8'h01);
        HOST.wr(ADDR_MODE_CTRL, 8'h29);
        chk(8'(safety_timeout_en), 8'h01);
        chk(8'(led_gate), 8'h05);
        $display("test pwm done");
    endtask

    task automatic t_fault();
        HOST.wr(ADDR_MODE_CTRL, 8'h39);
        chk(8'(ts_monitor_active), 8'h01);
        ovp_trip <= 1'b1;
        cyc(4);
        chk(8'(overvoltage_clamp), 8'h01);
        ovp_trip <= 1'b0;
        cyc(4);
        rdchk(ADDR_STATUS, 8'h04);
        rdchk(ADDR_STATUS, 8'h00);
        led_short <= 1'b1;
        cyc(4);
        led_short <= 1'b0;
        cyc(4);
        rdchk(ADDR_STATUS, 8'h04);
        ts_below_warn <= 1'b1;
        cyc(4);
        rdchk(ADDR_STATUS, 8'h01);
        rdchk(ADDR_MODE_CTRL, 8'h39);
        ts_below_hot <= 1'b1;
        cyc(4);
        rdchk(ADDR_MODE_CTRL, 8'h38);
        // mode cleared, so the monitor and its warning are off
        rdchk(ADDR_STATUS, 8'h1a);
        rdchk(ADDR_STATUS, 8'h00);
        HOST.wr(ADDR_MODE_CTRL, 8'h03);
        chk(8'(ts_monitor_active), 8'h00);
        HOST.wr(ADDR_MODE_CTRL, 8'h43);
        chk(8'(ts_monitor_active), 8'h01);
        {ts_below_warn, ts_below_hot} <= 2'b00;
        $display("test fault done");
    endtask

    task automatic t_die();
        HOST.wr(ADDR_MODE_CTRL, 8'h03);
        chk(8'({power_switch_en, rectifier_en}), 8'h03);
        chk(8'(die_monitor_active), 8'h01);
        uvlo_low <= 1'b1;
        cyc(4);
        chk(8'({power_switch_en, rectifier_en}), 8'h00);
        uvlo_low <= 1'b0;
        die_over_55 <= 1'b1;
        cyc(4);
        rdchk(ADDR_STATUS, 8'h08);
        die_over_70 <= 1'b1;
        cyc(4);
        rdchk(ADDR_STATUS, 8'h10);
        die_over_160 <= 1'b1;
        cyc(4);
        chk(8'({power_switch_en, rectifier_en}), 8'h00);
        die_over_160 <= 1'b0;
        die_below_140 <= 1'b1;
        cyc(4);
        chk(8'(power_switch_en), 8'h01);
        rdchk(ADDR_STATUS, 8'h18);
        rdchk(ADDR_STATUS, 8'h10);
        die_below_140 <= 1'b0;
        HOST.wr(ADDR_MODE_CTRL, 8'h02);
        die_over_160 <= 1'b1;
        cyc(4);
        die_over_160 <= 1'b0;
        die_below_140 <= 1'b1;
        cyc(4);
        rdchk(ADDR_MODE_CTRL, 8'h00);
        rdchk(ADDR_STATUS, 8'h18);
        rdchk(ADDR_STATUS, 8'h00);
        {die_over_55, die_over_70, die_below_140} <= 3'b000;
        $display("test die done");
    endtask

    // one flash ramp; mode byte and expected final steps given by caller
    task automatic flash(input logic [7:0] m, input logic [7:0] s);
        HOST.wr(ADDR_MODE_CTRL, m);
        cyc(500);
        rdchk(ADDR_RAMP, 8'h00);
        cyc(800);
        rdchk(ADDR_RAMP, s);
        HOST.wr(ADDR_MODE_CTRL, 8'h00);
        cyc(60);
        rdchk(ADDR_RAMP, 8'h00);
    endtask

    task automatic t_ramp();
        HOST.wr(ADDR_VOLTAGE, 8'h50);
        HOST.wr(ADDR_CURRENT_B, 8'h02);
        HOST.wr(ADDR_MODE_CTRL, 8'h82);
        cyc(1);
        chk(8'(droop_sample), 8'h01);
        cyc(2);
        chk(8'(droop_sample), 8'h00);
        chk(8'(droop_limit), 8'h05);
        HOST.wr(ADDR_MODE_CTRL, 8'h00);
        cyc(60);
        flash(8'h82, 8'h02);
        droop_trip <= 1'b1;
        flash(8'h82, 8'h00);
        flash(8'h02, 8'h02);
        tx_mask <= 1'b1;
        flash(8'h82, 8'h02);
        $display("test ramp done");
    endtask

    initial begin
        rst_n = 1'b0;
        {ts_below_warn, ts_below_hot, ovp_trip, led_short, uvlo_low} = '0;
        {die_over_55, die_over_70, die_over_160, die_below_140} = '0;
        {droop_trip, tx_mask} = '0;
        cyc(5);
        rst_n <= 1'b1;
        t_regs();
        t_ind_ov();
        t_pwm();
        t_fault();
        t_die();
        t_ramp();
        end_of_test();
    end

endmodule // lfp_ctrl_test

`default_nettype wire
